//--- design/bififo_pkg.sv
// Shared constants and carriers for the Port A side of the two-way queue
package bififo_pkg;

  localparam int DATA_W     = 18;
  localparam int DEPTH_DEF  = 256;
  localparam int OFFSET_DEF = 8;

  // Resource codes seen on resource_sel while the port is selected
  typedef logic [2:0] res_type;
  localparam res_type RES_DATA   = 3'h0;
  localparam res_type RES_A2B_AE = 3'h1;
  localparam res_type RES_A2B_AF = 3'h2;
  localparam res_type RES_B2A_AE = 3'h3;
  localparam res_type RES_B2A_AF = 3'h4;
  localparam res_type RES_STATUS = 3'h5;

  // Bit positions of the status word read at RES_STATUS
  localparam int ST_A2B_FULL_N   = 0;
  localparam int ST_A2B_AFULL_N  = 1;
  localparam int ST_B2A_EMPTY_N  = 2;
  localparam int ST_B2A_AEMPTY_N = 3;
  localparam int ST_BYPASS       = 4;

  // Port A pins as caught by the input register
  typedef struct packed {
    logic              sel_n;
    logic              dir;
    logic              xfer_n;
    res_type           res;
    logic [DATA_W-1:0] data;
  } a_pins_type;

  // Flags that face Port A
  typedef struct packed {
    logic a2b_full_n;
    logic a2b_almost_full_n;
    logic b2a_empty_n;
    logic b2a_almost_empty_n;
  } a_flags_type;

  // Flags that face the Port B side
  typedef struct packed {
    logic a2b_empty_n;
    logic a2b_almost_empty_n;
    logic b2a_full_n;
    logic b2a_almost_full_n;
  } b_flags_type;

endpackage

//--- design/bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
module bit_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Level in and synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule

//--- design/dual_clock_queue.sv
// Dual-clock queue with gray pointers and its own storage array
`timescale 1ns/100ps
module dual_clock_queue #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 256,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  // Write side
  input  wire logic             wr_clk,
  input  wire logic             wr_rst_n,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  full,
  output logic      [CW-1:0]    wr_count,
  // Read side
  input  wire logic             rd_clk,
  input  wire logic             rd_rst_n,
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  output logic                  empty,
  output logic      [CW-1:0]    rd_count
);

  localparam int AW = CW - 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("queue depth must be a power of two");
  end

  function automatic logic [CW-1:0] g2b(input logic [CW-1:0] g);
    logic [CW-1:0] b;
    b[CW-1] = g[CW-1];
    for (int i = CW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    wbin_r, wbin_nxt, wgray_r, rbin_r, rbin_nxt, rgray_r;
  logic [CW-1:0]    rgray_w, wgray_rd, rbin_w, wbin_rd;

  bit_sync #(.W(CW)) u_r2w (.clk(wr_clk), .rst_n(wr_rst_n),
                            .d(rgray_r), .q(rgray_w));
  bit_sync #(.W(CW)) u_w2r (.clk(rd_clk), .rst_n(rd_rst_n),
                            .d(wgray_r), .q(wgray_rd));

  always_comb begin
    rbin_w   = g2b(rgray_w);
    wbin_rd  = g2b(wgray_rd);
    wr_count = wbin_r - rbin_w;
    rd_count = wbin_rd - rbin_r;
    full     = (wr_count == CW'(DEPTH));
    empty    = (rd_count == '0);
    // A blocked access leaves pointers and storage untouched
    wbin_nxt = (wr_en && !full)  ? wbin_r + 1'b1 : wbin_r;
    rbin_nxt = (rd_en && !empty) ? rbin_r + 1'b1 : rbin_r;
    rd_data  = mem[rbin_r[AW-1:0]];
  end

  always_ff @(posedge wr_clk) begin
    if (wr_en && !full) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r  <= '0;
      rgray_r <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
    end
  end

endmodule

//--- design/bidir_fifo_port_a.sv
// Port A side of the two-way queue with bypass path
`timescale 1ns/100ps
module bidir_fifo_port_a #(
  parameter int DEPTH = bififo_pkg::DEPTH_DEF,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  // Core clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // Port A pins
  input  wire logic                          port_a_clk,
  input  wire logic                          port_a_select_n,
  input  wire logic                          port_a_direction,
  input  wire logic                          port_a_xfer_en_n,
  input  wire logic                          port_a_drive_en_n,
  input  wire bififo_pkg::res_type           resource_sel,
  input  wire logic [bififo_pkg::DATA_W-1:0] port_a_bus_in,
  output logic      [bififo_pkg::DATA_W-1:0] port_a_bus_out,
  output logic                               port_a_bus_oe_n,
  input  wire logic                          bypass_mode,
  output bififo_pkg::a_flags_type            a_flags,
  // Port B side, core clock
  input  wire logic                          b_rd_req,
  output logic      [bififo_pkg::DATA_W-1:0] b_rd_data,
  output logic                               b_rd_valid,
  input  wire logic                          b_wr_req,
  input  wire logic [bififo_pkg::DATA_W-1:0] b_wr_data,
  output bififo_pkg::b_flags_type            b_flags,
  output logic                               bypass_active_n
);

  localparam int DW = bififo_pkg::DATA_W;
  localparam logic [CW:0]   DEPTH_C = (CW + 1)'(DEPTH);
  localparam logic [CW-1:0] OFF_DEF = CW'(bififo_pkg::OFFSET_DEF);

  initial begin
    if (DEPTH != 256 && DEPTH != 512)
      $error("depth must be 256 or 512");
  end

  function automatic logic almost_empty(input logic [CW-1:0] cnt,
                                        input logic [CW-1:0] off);
    return cnt <= off;
  endfunction

  function automatic logic almost_full(input logic [CW-1:0] cnt,
                                       input logic [CW-1:0] off);
    return {1'b0, cnt} > (DEPTH_C - {1'b0, off});
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Port A domain reset, asserted at once, released on port_a_clk

  logic [1:0] a_rst_sh_r;
  logic       a_rst_n;

  always_ff @(posedge port_a_clk or negedge nrst) begin
    if (!nrst) begin
      a_rst_sh_r <= 2'h0;
    end else begin
      a_rst_sh_r <= {a_rst_sh_r[0], 1'b1};
    end
  end
  assign a_rst_n = a_rst_sh_r[1];

  //////////////////////////////////////////////////////////////////////////
  // Queues

  logic          a2b_wr, a2b_rd, b2a_wr, b2a_rd;
  logic          a2b_full, a2b_empty, b2a_full, b2a_empty;
  logic [CW-1:0] a2b_wcnt, a2b_rcnt, b2a_wcnt, b2a_rcnt;
  logic [DW-1:0] a2b_q, b2a_q;
  bififo_pkg::a_pins_type pin_r, pin_nxt;

  dual_clock_queue #(.WIDTH(DW), .DEPTH(DEPTH), .CW(CW)) u_a2b (
    .wr_clk   (port_a_clk),
    .wr_rst_n (a_rst_n),
    .wr_en    (a2b_wr),
    .wr_data  (pin_r.data),
    .full     (a2b_full),
    .wr_count (a2b_wcnt),
    .rd_clk   (sys_clk),
    .rd_rst_n (nrst),
    .rd_en    (a2b_rd),
    .rd_data  (a2b_q),
    .empty    (a2b_empty),
    .rd_count (a2b_rcnt)
  );

  dual_clock_queue #(.WIDTH(DW), .DEPTH(DEPTH), .CW(CW)) u_b2a (
    .wr_clk   (sys_clk),
    .wr_rst_n (nrst),
    .wr_en    (b2a_wr),
    .wr_data  (b_wr_data),
    .full     (b2a_full),
    .wr_count (b2a_wcnt),
    .rd_clk   (port_a_clk),
    .rd_rst_n (a_rst_n),
    .rd_en    (b2a_rd),
    .rd_data  (b2a_q),
    .empty    (b2a_empty),
    .rd_count (b2a_rcnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // Crossings between the two domains

  logic          a_put_tgl_r, a_take_tgl_r, off_tgl_r;
  logic          b_put_tgl_r, b_take_tgl_r;
  logic          b_put_tgl_a, b_take_tgl_a;
  logic          a_put_tgl_b, a_take_tgl_b, off_tgl_b, bypass_b;
  logic [DW-1:0] a2b_msg_r, b2a_msg_r;
  logic [CW-1:0] off_a2b_ae_r, off_a2b_af_r, off_b2a_ae_r, off_b2a_af_r;

  bit_sync #(.W(2)) u_to_a (
    .clk   (port_a_clk),
    .rst_n (a_rst_n),
    .d     ({b_put_tgl_r, b_take_tgl_r}),
    .q     ({b_put_tgl_a, b_take_tgl_a})
  );

  logic bypass_r;

  bit_sync #(.W(4)) u_to_b (
    .clk   (sys_clk),
    .rst_n (nrst),
    .d     ({a_put_tgl_r, a_take_tgl_r, off_tgl_r, bypass_r}),
    .q     ({a_put_tgl_b, a_take_tgl_b, off_tgl_b, bypass_b})
  );

  //////////////////////////////////////////////////////////////////////////
  // Port A domain

  logic          bypass_nxt, a_put_tgl_nxt, a_take_tgl_nxt, off_tgl_nxt;
  logic [DW-1:0] a2b_msg_nxt, a_out_nxt;
  logic          a_oe_n_nxt;
  logic [CW-1:0] off_a2b_ae_nxt, off_a2b_af_nxt;
  logic [CW-1:0] off_b2a_ae_nxt, off_b2a_af_nxt;
  logic          acc, wr_acc, rd_acc, data_res;
  logic          a_msg_waiting, b_msg_ready;
  bififo_pkg::a_flags_type a_flags_nxt;

  always_comb begin
    // Access pins are caught first, acted on at the next edge; the drive enable uses the live pins
    pin_nxt.sel_n  = port_a_select_n;
    pin_nxt.dir    = port_a_direction;
    pin_nxt.xfer_n = port_a_xfer_en_n;
    pin_nxt.res    = resource_sel;
    pin_nxt.data   = port_a_bus_in;
    bypass_nxt     = bypass_mode;

    acc      = !pin_r.sel_n && !pin_r.xfer_n;
    wr_acc   = acc && !pin_r.dir;
    rd_acc   = acc && pin_r.dir;
    data_res = (pin_r.res == bififo_pkg::RES_DATA);

    a_msg_waiting = (a_put_tgl_r != b_take_tgl_a);
    b_msg_ready   = (b_put_tgl_a != a_take_tgl_r);

    // Queue path, blocked on full or empty
    a2b_wr = wr_acc && data_res && !bypass_r && !a2b_full;
    b2a_rd = rd_acc && data_res && !bypass_r && !b2a_empty;

    a2b_msg_nxt    = a2b_msg_r;
    a_put_tgl_nxt  = a_put_tgl_r;
    a_take_tgl_nxt = a_take_tgl_r;
    a_out_nxt      = port_a_bus_out;
    off_a2b_ae_nxt = off_a2b_ae_r;
    off_a2b_af_nxt = off_a2b_af_r;
    off_b2a_ae_nxt = off_b2a_ae_r;
    off_b2a_af_nxt = off_b2a_af_r;
    off_tgl_nxt    = off_tgl_r;

    // Bypass message path, no queue storage involved
    if (wr_acc && data_res && bypass_r && !a_msg_waiting) begin
      a2b_msg_nxt   = pin_r.data;
      a_put_tgl_nxt = !a_put_tgl_r;
    end
    if (rd_acc && data_res && bypass_r && b_msg_ready) begin
      a_out_nxt      = b2a_msg_r;
      a_take_tgl_nxt = !a_take_tgl_r;
    end
    if (b2a_rd) begin
      a_out_nxt = b2a_q;
    end

    // Threshold registers
    if (wr_acc) begin
      unique case (pin_r.res)
        bififo_pkg::RES_A2B_AE: begin
          off_a2b_ae_nxt = pin_r.data[CW-1:0];
          off_tgl_nxt    = !off_tgl_r;
        end
        bififo_pkg::RES_A2B_AF: off_a2b_af_nxt = pin_r.data[CW-1:0];
        bififo_pkg::RES_B2A_AE: off_b2a_ae_nxt = pin_r.data[CW-1:0];
        bififo_pkg::RES_B2A_AF: begin
          off_b2a_af_nxt = pin_r.data[CW-1:0];
          off_tgl_nxt    = !off_tgl_r;
        end
        default: ;
      endcase
    end
    if (rd_acc) begin
      unique case (pin_r.res)
        bififo_pkg::RES_A2B_AE: a_out_nxt = DW'(off_a2b_ae_r);
        bififo_pkg::RES_A2B_AF: a_out_nxt = DW'(off_a2b_af_r);
        bififo_pkg::RES_B2A_AE: a_out_nxt = DW'(off_b2a_ae_r);
        bififo_pkg::RES_B2A_AF: a_out_nxt = DW'(off_b2a_af_r);
        bififo_pkg::RES_STATUS: begin
          a_out_nxt = '0;
          a_out_nxt[bififo_pkg::ST_A2B_FULL_N]   = a_flags.a2b_full_n;
          a_out_nxt[bififo_pkg::ST_A2B_AFULL_N]  = a_flags.a2b_almost_full_n;
          a_out_nxt[bififo_pkg::ST_B2A_EMPTY_N]  = a_flags.b2a_empty_n;
          a_out_nxt[bififo_pkg::ST_B2A_AEMPTY_N] =
            a_flags.b2a_almost_empty_n;
          a_out_nxt[bififo_pkg::ST_BYPASS]       = bypass_r;
        end
        default: ;
      endcase
    end

    // Drive only for a selected read with drive enable low
    a_oe_n_nxt = !(!port_a_select_n && !port_a_drive_en_n
                   && port_a_direction);

    // Fixed and programmable flags; bypass shows message state
    if (bypass_r) begin
      a_flags_nxt.a2b_full_n = !a_msg_waiting;
      a_flags_nxt.b2a_empty_n = b_msg_ready;
    end else begin
      a_flags_nxt.a2b_full_n = !a2b_full;
      a_flags_nxt.b2a_empty_n = !b2a_empty;
    end
    a_flags_nxt.a2b_almost_full_n =
      !almost_full(a2b_wcnt, off_a2b_af_r);
    a_flags_nxt.b2a_almost_empty_n =
      !almost_empty(b2a_rcnt, off_b2a_ae_r);
  end

  always_ff @(posedge port_a_clk or negedge a_rst_n) begin
    if (!a_rst_n) begin
      // Everything back to its initial state
      pin_r           <= '{sel_n: 1'b1, dir: 1'b0, xfer_n: 1'b1,
                           res: bififo_pkg::RES_DATA, data: '0};
      bypass_r        <= 1'b0;
      a2b_msg_r       <= '0;
      a_put_tgl_r     <= 1'b0;
      a_take_tgl_r    <= 1'b0;
      port_a_bus_out  <= '0;
      port_a_bus_oe_n <= 1'b1;
      off_a2b_ae_r    <= OFF_DEF;
      off_a2b_af_r    <= OFF_DEF;
      off_b2a_ae_r    <= OFF_DEF;
      off_b2a_af_r    <= OFF_DEF;
      off_tgl_r       <= 1'b0;
      a_flags         <= '{a2b_full_n: 1'b1, a2b_almost_full_n: 1'b1,
                           b2a_empty_n: 1'b0, b2a_almost_empty_n: 1'b0};
    end else begin
      pin_r           <= pin_nxt;
      bypass_r        <= bypass_nxt;
      a2b_msg_r       <= a2b_msg_nxt;
      a_put_tgl_r     <= a_put_tgl_nxt;
      a_take_tgl_r    <= a_take_tgl_nxt;
      port_a_bus_out  <= a_out_nxt;
      port_a_bus_oe_n <= a_oe_n_nxt;
      off_a2b_ae_r    <= off_a2b_ae_nxt;
      off_a2b_af_r    <= off_a2b_af_nxt;
      off_b2a_ae_r    <= off_b2a_ae_nxt;
      off_b2a_af_r    <= off_b2a_af_nxt;
      off_tgl_r       <= off_tgl_nxt;
      a_flags         <= a_flags_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core domain (Port B side)

  logic          off_seen_r, off_seen_nxt;
  logic [CW-1:0] sh_ae_r, sh_ae_nxt, sh_af_r, sh_af_nxt;
  logic          b_put_tgl_nxt, b_take_tgl_nxt, b_valid_nxt;
  logic [DW-1:0] b2a_msg_nxt, b_data_nxt;
  logic          a_msg_ready_b, b_msg_waiting;
  bififo_pkg::b_flags_type b_flags_nxt;

  always_comb begin
    a_msg_ready_b = (a_put_tgl_b != b_take_tgl_r);
    b_msg_waiting = (b_put_tgl_r != a_take_tgl_b);

    a2b_rd = b_rd_req && !bypass_b && !a2b_empty;
    b2a_wr = b_wr_req && !bypass_b && !b2a_full;

    b2a_msg_nxt    = b2a_msg_r;
    b_put_tgl_nxt  = b_put_tgl_r;
    b_take_tgl_nxt = b_take_tgl_r;
    b_data_nxt     = b_rd_data;
    b_valid_nxt    = 1'b0;

    if (a2b_rd) begin
      b_data_nxt  = a2b_q;
      b_valid_nxt = 1'b1;
    end
    // Bypass words held stable until the far side toggles back
    if (b_rd_req && bypass_b && a_msg_ready_b) begin
      b_data_nxt     = a2b_msg_r;
      b_valid_nxt    = 1'b1;
      b_take_tgl_nxt = !b_take_tgl_r;
    end
    if (b_wr_req && bypass_b && !b_msg_waiting) begin
      b2a_msg_nxt   = b_wr_data;
      b_put_tgl_nxt = !b_put_tgl_r;
    end

    // Thresholds are copied when their change toggle arrives
    off_seen_nxt = off_tgl_b;
    sh_ae_nxt    = (off_tgl_b != off_seen_r) ? off_a2b_ae_r : sh_ae_r;
    sh_af_nxt    = (off_tgl_b != off_seen_r) ? off_b2a_af_r : sh_af_r;

    if (bypass_b) begin
      b_flags_nxt.a2b_empty_n = a_msg_ready_b;
      b_flags_nxt.b2a_full_n  = !b_msg_waiting;
    end else begin
      b_flags_nxt.a2b_empty_n = !a2b_empty;
      b_flags_nxt.b2a_full_n  = !b2a_full;
    end
    b_flags_nxt.a2b_almost_empty_n = !almost_empty(a2b_rcnt, sh_ae_r);
    b_flags_nxt.b2a_almost_full_n  = !almost_full(b2a_wcnt, sh_af_r);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      b2a_msg_r       <= '0;
      b_put_tgl_r     <= 1'b0;
      b_take_tgl_r    <= 1'b0;
      b_rd_data       <= '0;
      b_rd_valid      <= 1'b0;
      off_seen_r      <= 1'b0;
      sh_ae_r         <= OFF_DEF;
      sh_af_r         <= OFF_DEF;
      bypass_active_n <= 1'b1;
      b_flags         <= '{a2b_empty_n: 1'b0, a2b_almost_empty_n: 1'b0,
                           b2a_full_n: 1'b1, b2a_almost_full_n: 1'b1};
    end else begin
      b2a_msg_r       <= b2a_msg_nxt;
      b_put_tgl_r     <= b_put_tgl_nxt;
      b_take_tgl_r    <= b_take_tgl_nxt;
      b_rd_data       <= b_data_nxt;
      b_rd_valid      <= b_valid_nxt;
      off_seen_r      <= off_seen_nxt;
      sh_ae_r         <= sh_ae_nxt;
      sh_af_r         <= sh_af_nxt;
      bypass_active_n <= !bypass_b;
      b_flags         <= b_flags_nxt;
    end
  end

endmodule

//--- verification/bififo_port_a_monitor.sv
// Port-level checks on the Port A side of the two-way queue
`timescale 1ns/100ps
module bififo_port_a_monitor (
  // Clocks and reset
  input wire logic                          sys_clk,
  input wire logic                          nrst,
  input wire logic                          port_a_clk,
  // Port A
  input wire logic                          port_a_select_n,
  input wire logic                          port_a_direction,
  input wire logic                          port_a_xfer_en_n,
  input wire logic                          port_a_drive_en_n,
  input wire bififo_pkg::res_type           resource_sel,
  input wire logic [bififo_pkg::DATA_W-1:0] port_a_bus_out,
  input wire logic                          port_a_bus_oe_n,
  input wire logic                          bypass_mode,
  input wire bififo_pkg::a_flags_type       a_flags,
  // Port B side
  input wire logic                          b_rd_req,
  input wire logic                          b_rd_valid,
  input wire bififo_pkg::b_flags_type       b_flags,
  input wire logic                          bypass_active_n
);
  logic rd_cmd;
  logic wr_cmd;
  logic drv_cmd;
  assign rd_cmd = !port_a_select_n && !port_a_xfer_en_n && port_a_direction;
  assign wr_cmd = !port_a_select_n && !port_a_xfer_en_n && !port_a_direction
                  && resource_sel == bififo_pkg::RES_DATA && bypass_mode;
  assign drv_cmd = !port_a_select_n && !port_a_drive_en_n && port_a_direction;

  a_drive_on_read: assert property (@(posedge port_a_clk)
    disable iff (!nrst) drv_cmd |=> !port_a_bus_oe_n)
    else $error("bus not driven for a selected read");
  a_float_otherwise: assert property (@(posedge port_a_clk)
    disable iff (!nrst) !drv_cmd |=> port_a_bus_oe_n)
    else $error("bus driven without a selected read");
  a_out_needs_read: assert property (@(posedge port_a_clk)
    disable iff (!nrst) !$stable(port_a_bus_out) |-> $past(rd_cmd, 2))
    else $error("read data changed without an enabled read");
  a_byp_full_set: assert property (@(posedge port_a_clk)
    disable iff (!nrst) wr_cmd |-> ##[1:3] !a_flags.a2b_full_n)
    else $error("bypass write did not mark message waiting");
  a_byp_read_empty: assert property (@(posedge port_a_clk)
    disable iff (!nrst)
    (rd_cmd && bypass_mode && resource_sel == bififo_pkg::RES_DATA
     && a_flags.b2a_empty_n) |-> ##[1:3] !a_flags.b2a_empty_n)
    else $error("empty flag stayed high after bypass read");
  a_rst_a_flags: assert property (@(posedge port_a_clk)
    disable iff (!nrst)
    $rose(nrst) |-> a_flags.a2b_full_n && !a_flags.b2a_empty_n)
    else $error("Port A flags wrong after reset");
  a_rst_b_flags: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    $rose(nrst) |-> b_flags.b2a_full_n && !b_flags.a2b_empty_n)
    else $error("Port B flags wrong after reset");
  a_valid_has_req: assert property (@(posedge sys_clk)
    disable iff (!nrst) b_rd_valid |-> $past(b_rd_req))
    else $error("read valid without a request");
  a_bypass_seen: assert property (@(posedge sys_clk)
    disable iff (!nrst)
    $changed(bypass_mode) |-> ##[1:10] bypass_active_n == !bypass_mode)
    else $error("bypass indication did not follow mode");
endmodule

bind bidir_fifo_port_a bififo_port_a_monitor bififo_port_a_monitor_i (
  .sys_clk(sys_clk), .nrst(nrst), .port_a_clk(port_a_clk),
  .port_a_select_n(port_a_select_n), .port_a_direction(port_a_direction),
  .port_a_xfer_en_n(port_a_xfer_en_n),
  .port_a_drive_en_n(port_a_drive_en_n), .resource_sel(resource_sel),
  .port_a_bus_out(port_a_bus_out), .port_a_bus_oe_n(port_a_bus_oe_n),
  .bypass_mode(bypass_mode), .a_flags(a_flags), .b_rd_req(b_rd_req),
  .b_rd_valid(b_rd_valid), .b_flags(b_flags),
  .bypass_active_n(bypass_active_n)
);

//--- verification/port_a_master.sv
// Bus master model for Port A with resolution of the shared bus wire
`timescale 1ns/100ps
module port_a_master (
  // Link clock
  input  wire logic                          port_a_clk,
  // Pins toward the device
  output logic                               port_a_select_n,
  output logic                               port_a_direction,
  output logic                               port_a_xfer_en_n,
  output logic                               port_a_drive_en_n,
  output bififo_pkg::res_type                resource_sel,
  // Bus wire
  input  wire logic [bififo_pkg::DATA_W-1:0] port_a_bus_out,
  input  wire logic                          port_a_bus_oe_n,
  output logic      [bififo_pkg::DATA_W-1:0] port_a_bus_in
);
  logic [bififo_pkg::DATA_W-1:0] data_r;
  logic [bififo_pkg::DATA_W-1:0] last_r;

  initial begin
    port_a_select_n = 1'b1;
    port_a_direction = 1'b0;
    port_a_xfer_en_n = 1'b1;
    port_a_drive_en_n = 1'b1;
    resource_sel = bififo_pkg::RES_DATA;
    data_r = '0;
    last_r = '0;
  end

  // Undriven bus shows a level that flips every cycle
  always @(posedge port_a_clk) last_r <= port_a_bus_in;
  always_comb begin
    if (!port_a_bus_oe_n)
      port_a_bus_in = port_a_bus_out;
    else if (!port_a_select_n && !port_a_direction)
      port_a_bus_in = data_r;
    else
      port_a_bus_in = ~last_r;
  end

  // One access: pins set after a falling edge, held over one rising edge
  task automatic access(logic dir, bififo_pkg::res_type r,
                        logic [bififo_pkg::DATA_W-1:0] x, logic sel_n,
                        logic xfer_n);
    @(negedge port_a_clk);
    port_a_select_n = sel_n;
    port_a_direction = dir;
    port_a_xfer_en_n = xfer_n;
    port_a_drive_en_n = !dir;
    resource_sel = r;
    data_r = x;
    @(negedge port_a_clk);
    port_a_select_n = 1'b1;
    port_a_xfer_en_n = 1'b1;
    port_a_drive_en_n = 1'b1;
  endtask
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the Port A side of the two-way queue
`timescale 1ns/100ps
module tb_top;
  localparam int W = bififo_pkg::DATA_W;
  logic                    sys_clk, nrst, port_a_clk, bypass_mode;
  logic                    b_rd_req, b_wr_req, b_rd_valid, bypass_active_n;
  logic                    sel_n, dir, xfer_n, drv_n, oe_n;
  logic [W-1:0]            b_wr_data, b_rd_data, bus_in, bus_out;
  bififo_pkg::res_type     res;
  bififo_pkg::a_flags_type a_flags;
  bififo_pkg::b_flags_type b_flags;
  int                      fail_count = 0;
  int                      total_checks = 0;

  bidir_fifo_port_a bidir_fifo_port_a_i (
    .sys_clk(sys_clk), .nrst(nrst), .port_a_clk(port_a_clk),
    .port_a_select_n(sel_n), .port_a_direction(dir),
    .port_a_xfer_en_n(xfer_n), .port_a_drive_en_n(drv_n),
    .resource_sel(res), .port_a_bus_in(bus_in), .port_a_bus_out(bus_out),
    .port_a_bus_oe_n(oe_n), .bypass_mode(bypass_mode), .a_flags(a_flags),
    .b_rd_req(b_rd_req), .b_rd_data(b_rd_data), .b_rd_valid(b_rd_valid),
    .b_wr_req(b_wr_req), .b_wr_data(b_wr_data), .b_flags(b_flags),
    .bypass_active_n(bypass_active_n));
  port_a_master port_a_master_i (
    .port_a_clk(port_a_clk), .port_a_select_n(sel_n),
    .port_a_direction(dir), .port_a_xfer_en_n(xfer_n),
    .port_a_drive_en_n(drv_n), .resource_sel(res),
    .port_a_bus_out(bus_out), .port_a_bus_oe_n(oe_n),
    .port_a_bus_in(bus_in));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    port_a_clk = 1'b0;
    #3;
    forever #7.5 port_a_clk = ~port_a_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [W-1:0] e, logic [W-1:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic a_wr(bififo_pkg::res_type r, logic [W-1:0] x);
    port_a_master_i.access(1'b0, r, x, 1'b0, 1'b0);
  endtask
  task automatic a_rd(bififo_pkg::res_type r, logic [W-1:0] e,
                      logic [W-1:0] m);
    port_a_master_i.access(1'b1, r, '0, 1'b0, 1'b0);
    @(negedge port_a_clk);
    chk("port_a_bus_out", e, bus_out & m);
  endtask
  task automatic b_rd(logic v, logic [W-1:0] e);
    @(negedge sys_clk) b_rd_req = 1'b1;
    @(negedge sys_clk) b_rd_req = 1'b0;
    chk("b_rd_valid", W'(v), W'(b_rd_valid));
    if (v)
      chk("b_rd_data", e, b_rd_data);
  endtask
  task automatic b_wr(logic [W-1:0] x);
    @(negedge sys_clk);
    b_wr_req = 1'b1;
    b_wr_data = x;
    @(negedge sys_clk) b_wr_req = 1'b0;
  endtask
  task automatic wait_b();
    for (int i = 0; i < 50 && b_flags.a2b_empty_n !== 1'b1; i++)
      @(negedge sys_clk);
  endtask
  task automatic wait_a();
    for (int i = 0; i < 50 && a_flags.b2a_empty_n !== 1'b1; i++)
      @(negedge port_a_clk);
  endtask
  task automatic rst();
    nrst = 1'b0;
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge port_a_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    bypass_mode = 1'b0;
    b_rd_req = 1'b0;
    b_wr_req = 1'b0;
    b_wr_data = '0;
    rst();
    for (int r = 1; r < 5; r++)
      a_rd(bififo_pkg::res_type'(r), 18'h8, '1);
    a_rd(bififo_pkg::RES_STATUS, 18'h3, 18'h1f);
    for (int r = 1; r < 5; r++)
      a_wr(bififo_pkg::res_type'(r), W'(r));
    for (int r = 1; r < 5; r++)
      a_rd(bififo_pkg::res_type'(r), W'(r), '1);
    port_a_master_i.access(1'b0, bififo_pkg::RES_DATA, 18'h11, 1'b1, 1'b0);
    port_a_master_i.access(1'b0, bififo_pkg::RES_DATA, 18'h12, 1'b0, 1'b1);
    a_wr(bififo_pkg::RES_DATA, 18'h2a);
    wait_b();
    b_rd(1'b1, 18'h2a);
    b_rd(1'b0, '0);
    for (int i = 0; i < 257; i++)
      a_wr(bififo_pkg::RES_DATA, W'(i));
    repeat (3) @(negedge port_a_clk);
    chk("a2b_full_n", '0, W'(a_flags.a2b_full_n));
    for (int i = 0; i < 256; i++)
      b_rd(1'b1, W'(i));
    b_rd(1'b0, '0);
    for (int k = 0; k < 4; k++)
      b_wr(W'(18'h100 + k));
    for (int i = 0; i < 50 && a_flags.b2a_almost_empty_n !== 1'b1; i++)
      @(negedge port_a_clk);
    chk("b2a_almost_empty_n", 18'h1, W'(a_flags.b2a_almost_empty_n));
    a_rd(bififo_pkg::RES_DATA, 18'h100, '1);
    repeat (2) @(negedge port_a_clk);
    chk("b2a_almost_empty_n", '0, W'(a_flags.b2a_almost_empty_n));
    for (int k = 1; k < 4; k++)
      a_rd(bififo_pkg::RES_DATA, W'(18'h100 + k), '1);
    a_rd(bififo_pkg::RES_DATA, 18'h103, '1);
    chk("b2a_empty_n", '0, W'(a_flags.b2a_empty_n));
    @(negedge port_a_clk) bypass_mode = 1'b1;
    repeat (12) @(negedge sys_clk);
    chk("bypass_active_n", '0, W'(bypass_active_n));
    a_wr(bififo_pkg::RES_DATA, 18'h3c5a5);
    wait_b();
    b_rd(1'b1, 18'h3c5a5);
    b_wr(18'h1234f);
    wait_a();
    a_rd(bififo_pkg::RES_DATA, 18'h1234f, '1);
    repeat (2) @(negedge port_a_clk);
    chk("b2a_empty_n", '0, W'(a_flags.b2a_empty_n));
    @(negedge port_a_clk) bypass_mode = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk("bypass_active_n", 18'h1, W'(bypass_active_n));
    rst();
    a_rd(bififo_pkg::RES_B2A_AE, 18'h8, '1);
    a_rd(bififo_pkg::RES_STATUS, 18'h3, 18'h1f);
    conclude();
  end
endmodule
